// File: verilog/flash_seq_map.svh
// Constants of the serial flash command sequencer
// What this block does
// - Fast read: command, 24-bit address, dummy byte in; data out on falling edges.
// - Read address increments after each byte and wraps to zero past the top.
// - Raising select during data output stops the output driver at once.
// - Fast read is rejected while a program or erase cycle runs.
// - Programming only clears bits; only erase sets them back to one.
// - Program and erase need the write latch flag set by write-enable.
// - Program data past the page end wraps to the same page start.
// - Over 256 bytes keeps the last 256; fewer leave other bytes untouched.
// - Program runs only if select rises right after a whole data byte.
// - Valid program or erase starts a timed busy cycle; write latch clears early.
// - No program into a page protected by the protect-level bits.
// - Sector erase: command plus address, select rises after last address byte.
// - No sector erase of a protected sector.
// - Bulk erase is the command byte alone, select rising right after it.
// - Bulk erase only when both protect-level bits are zero.
// - In deep power-down only the release command is obeyed; it wakes the device.
// - Deep power-down is entered after the entry delay once select rises.
// - Deep power-down command is rejected while a program or erase cycle runs.
// - Release: command, three dummy bytes, then signature repeated on falling edges.
// - Leaving power-down takes the early or late release delay.
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH
`define CLK_PERIOD_NS 25
`define NS_PER_US 1000
`define CMD_WREN 8'hA1
`define CMD_WRDI 8'hA2
`define CMD_FREAD 8'hA3
`define CMD_PROG 8'hA4
`define CMD_SERASE 8'hA5
`define CMD_BERASE 8'hA6
`define CMD_PDOWN 8'hA7
`define CMD_RELEASE 8'hA8
`define ADDR_W 18
`define TMR_W 28
`define PTMR_W 12
`define PDOWN_DELAY_US 3
`define REL_EARLY_US 3
`define REL_LATE_US 2
`define PDOWN_CYC 12'(((`PDOWN_DELAY_US * `NS_PER_US) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REL_EARLY_CYC 12'(((`REL_EARLY_US * `NS_PER_US) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REL_LATE_CYC 12'(((`REL_LATE_US * `NS_PER_US) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: verilog/flash_seq_pkg.sv
// Types of the serial flash command sequencer
package flash_seq_pkg;
   typedef enum logic [9:0] {
      S_IDLE = 10'h001, S_CMD = 10'h002, S_ADDR = 10'h004, S_DUMMY = 10'h008, S_READ = 10'h010,
      S_PDATA = 10'h020, S_RDUM = 10'h040, S_SIG = 10'h080, S_HOLD = 10'h100, S_SKIP = 10'h200
   } frame_st_t;
   typedef enum logic [3:0] {OP_IDLE = 4'h1, OP_PROG = 4'h2, OP_SERASE = 4'h4, OP_BERASE = 4'h8} op_t;
   typedef enum logic [3:0] {PW_STBY = 4'h1, PW_ENTER = 4'h2, PW_DOWN = 4'h4, PW_LEAVE = 4'h8} pwr_t;
endpackage

// File: verilog/serial_flash_cmd_sequencer.sv
// Command sequencer of a serial flash: frame decode, page buffer, timed cycles
`timescale 1ns/100ps
`include "flash_seq_map.svh"
module serial_flash_cmd_sequencer
   import flash_seq_pkg::*;
#(
   parameter int unsigned PROG_TIME_US = 1000,
   parameter int unsigned SERASE_TIME_US = 1000000,
   parameter int unsigned BERASE_TIME_US = 4000000,
   parameter logic [7:0] SIGNATURE = 8'h5A // Arbitrary value
)(
   input wire logic SYS_CLK,
   input wire logic RESET,
   input wire logic SEL_N,
   input wire logic SCLK,
   input wire logic SERIAL_IN,
   output logic SERIAL_OUT,
   output logic SERIAL_OUT_OE,
   input wire logic PROTECT_LEVEL_HI,
   input wire logic PROTECT_LEVEL_LO,
   output logic BUSY_FLAG,
   output logic WRITE_LATCH_FLAG,
   output logic POWERED_DOWN,
   output logic [17:0] MEM_ADDR,
   input wire logic [7:0] MEM_RDATA,
   output logic MEM_WE,
   output logic [7:0] MEM_WDATA,
   output logic MEM_SECTOR_ERASE,
   output logic MEM_BULK_ERASE
);
   localparam longint PROG_CYC = (longint'(PROG_TIME_US) * `NS_PER_US + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam longint SE_CYC = (longint'(SERASE_TIME_US) * `NS_PER_US + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam longint BE_CYC = (longint'(BERASE_TIME_US) * `NS_PER_US + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

   logic [2:0] sel_q, clk_q;
   logic [1:0] din_q;
   frame_st_t st_q;
   op_t op_q;
   pwr_t pw_q;
   logic [2:0] bit_q, obit_q;
   logic [1:0] nb_q;
   logic [7:0] sh_q, kind_q, osh_q;
   logic [`ADDR_W-1:0] addr_q, wa_q;
   logic got_q, rel_q, wel_q, sigd_q, out_q, oe_q;
   logic [7:0] pbuf_q [256];
   logic [255:0] pval_q;
   logic [`TMR_W-1:0] tmr_q;
   logic [`PTMR_W-1:0] ptmr_q;
   logic [8:0] idx_q;
   logic [1:0] ph_q;
   logic [9:0] page_q;
   logic we_q, serase_q, berase_q;
   logic [7:0] wdata_q;

   logic active, rise, fall, sel_rise, byte_done, busy, pdown, start_op;
   logic exec_pp, exec_se, exec_be, exec_dp, exec_wren, exec_wrdi, rel_go;
   logic [7:0] byte_in;
   logic [1:0] bp;

   function automatic logic prot(input logic [1:0] lvl, input logic [1:0] sec);
      prot = (lvl == 2'h3) || (lvl == 2'h2 && sec[1]) || (lvl == 2'h1 && sec == 2'h3);
   endfunction

   // Pins are asynchronous to SYS_CLK; stage 0 feeds only stage 1
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         sel_q <= 3'h7;
         clk_q <= 3'h0;
         din_q <= 2'h0;
      end
      else
      begin
         sel_q <= {sel_q[1:0], SEL_N};
         clk_q <= {clk_q[1:0], SCLK};
         din_q <= {din_q[0], SERIAL_IN};
      end
   end

   assign bp = {PROTECT_LEVEL_HI, PROTECT_LEVEL_LO};
   assign active = ~sel_q[1];
   assign sel_rise = sel_q[1] & ~sel_q[2];
   assign rise = active & clk_q[1] & ~clk_q[2];
   assign fall = active & ~clk_q[1] & clk_q[2];
   assign byte_in = {sh_q[6:0], din_q[1]};
   assign byte_done = rise && bit_q == 3'h7;
   assign busy = op_q != OP_IDLE;
   assign pdown = pw_q != PW_STBY;

   // Commands other than release act only when select rises on a byte boundary of the right byte
   assign exec_pp = sel_rise && st_q == S_PDATA && bit_q == 3'h0 && got_q
                    && !prot(bp, addr_q[17:16]);
   assign exec_se = sel_rise && st_q == S_HOLD && kind_q == `CMD_SERASE && !prot(bp, addr_q[17:16]);
   assign exec_be = sel_rise && st_q == S_HOLD && kind_q == `CMD_BERASE && bp == 2'h0;
   assign exec_dp = sel_rise && st_q == S_HOLD && kind_q == `CMD_PDOWN;
   assign exec_wren = sel_rise && st_q == S_HOLD && kind_q == `CMD_WREN;
   assign exec_wrdi = sel_rise && st_q == S_HOLD && kind_q == `CMD_WRDI;
   assign rel_go = sel_rise && rel_q;
   assign start_op = exec_pp || exec_se || exec_be;

   always_ff @(posedge SYS_CLK)
   begin
      if (RESET || !active)
      begin
         st_q <= S_IDLE;
         bit_q <= 3'h0;
         nb_q <= 2'h0;
         got_q <= 1'b0;
         rel_q <= 1'b0;
      end
      else if (st_q == S_IDLE)
         st_q <= S_CMD;
      else if (rise)
      begin
         sh_q <= byte_in;
         bit_q <= bit_q + 3'h1;
         if (st_q == S_HOLD)
            st_q <= S_SKIP;
         else if (byte_done)
         begin
            unique case (st_q)
               S_CMD:
               begin
                  kind_q <= byte_in;
                  nb_q <= 2'h0;
                  if (byte_in == `CMD_RELEASE)
                  begin
                     rel_q <= !busy;
                     st_q <= busy ? S_SKIP : S_RDUM;
                  end
                  else if (pdown || busy)
                     st_q <= S_SKIP;
                  else if (byte_in == `CMD_FREAD)
                     st_q <= S_ADDR;
                  else if (byte_in == `CMD_PROG || byte_in == `CMD_SERASE)
                     st_q <= wel_q ? S_ADDR : S_SKIP;
                  else if (byte_in == `CMD_BERASE)
                     st_q <= wel_q ? S_HOLD : S_SKIP;
                  else if (byte_in == `CMD_PDOWN || byte_in == `CMD_WREN || byte_in == `CMD_WRDI)
                     st_q <= S_HOLD;
                  else
                     st_q <= S_SKIP;
               end
               S_ADDR:
               begin
                  addr_q <= {addr_q[9:0], byte_in};
                  nb_q <= nb_q + 2'h1;
                  if (nb_q == 2'h2)
                     st_q <= kind_q == `CMD_FREAD ? S_DUMMY : kind_q == `CMD_PROG ? S_PDATA : S_HOLD;
               end
               S_DUMMY:
                  st_q <= S_READ;
               S_PDATA:
               begin
                  got_q <= 1'b1;
                  addr_q[7:0] <= addr_q[7:0] + 8'h01;
               end
               S_RDUM:
               begin
                  nb_q <= nb_q + 2'h1;
                  if (nb_q == 2'h2)
                     st_q <= S_SIG;
               end
               S_READ, S_SIG, S_SKIP, S_IDLE, S_HOLD: ;
               default: st_q <= S_SKIP;
            endcase
         end
      end
      else if (fall && st_q == S_READ && obit_q == 3'h0)
         addr_q <= addr_q + 18'h00001;
   end

   // Page buffer keeps the newest byte per position
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET || (byte_done && st_q == S_ADDR && nb_q == 2'h2))
         pval_q <= '0;
      else if (byte_done && st_q == S_PDATA)
      begin
         pbuf_q[addr_q[7:0]] <= byte_in;
         pval_q[addr_q[7:0]] <= 1'b1;
      end
   end

   // Output shifter; enable drops as soon as select is seen high
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET || !active)
      begin
         obit_q <= 3'h0;
         out_q <= 1'b0;
         oe_q <= 1'b0;
         if (RESET || st_q == S_IDLE)
            sigd_q <= 1'b0;
      end
      else if (fall && (st_q == S_READ || st_q == S_SIG))
      begin
         oe_q <= 1'b1;
         obit_q <= obit_q + 3'h1;
         if (obit_q == 3'h0)
         begin
            out_q <= st_q == S_READ ? MEM_RDATA[7] : SIGNATURE[7];
            osh_q <= st_q == S_READ ? {MEM_RDATA[6:0], 1'b0} : {SIGNATURE[6:0], 1'b0};
         end
         else
         begin
            out_q <= osh_q[7];
            osh_q <= {osh_q[6:0], 1'b0};
         end
         if (st_q == S_SIG && obit_q == 3'h7)
            sigd_q <= 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (RESET || start_op || exec_wrdi)
         wel_q <= 1'b0;
      else if (exec_wren)
         wel_q <= 1'b1;
   end

   // Self-timed cycle; the read-modify-write keeps stored zeros
   always_ff @(posedge SYS_CLK)
   begin
      we_q <= 1'b0;
      serase_q <= 1'b0;
      berase_q <= 1'b0;
      if (RESET)
      begin
         op_q <= OP_IDLE;
         tmr_q <= '0;
         idx_q <= 9'h000;
         ph_q <= 2'h0;
      end
      else if (!busy)
      begin
         page_q <= addr_q[17:8];
         wa_q <= addr_q;
         idx_q <= 9'h000;
         ph_q <= 2'h0;
         if (exec_pp)
         begin
            op_q <= OP_PROG;
            tmr_q <= `TMR_W'(PROG_CYC);
         end
         else if (exec_se)
         begin
            op_q <= OP_SERASE;
            tmr_q <= `TMR_W'(SE_CYC);
            serase_q <= 1'b1;
         end
         else if (exec_be)
         begin
            op_q <= OP_BERASE;
            tmr_q <= `TMR_W'(BE_CYC);
            berase_q <= 1'b1;
         end
      end
      else
      begin
         if (tmr_q != '0)
            tmr_q <= tmr_q - `TMR_W'(1);
         else if (op_q != OP_PROG || idx_q[8])
            op_q <= OP_IDLE;
         if (op_q == OP_PROG && !idx_q[8])
         begin
            if (!pval_q[idx_q[7:0]])
               idx_q <= idx_q + 9'h001;
            else if (ph_q == 2'h0)
            begin
               wa_q <= {page_q, idx_q[7:0]};
               ph_q <= 2'h1;
            end
            else if (ph_q == 2'h1)
               ph_q <= 2'h2;
            else
            begin
               we_q <= 1'b1;
               wdata_q <= MEM_RDATA & pbuf_q[idx_q[7:0]];
               ph_q <= 2'h0;
               idx_q <= idx_q + 9'h001;
            end
         end
      end
   end

   // Deep power-down entry and release timing
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         pw_q <= PW_STBY;
         ptmr_q <= '0;
      end
      else if (exec_dp)
      begin
         pw_q <= PW_ENTER;
         ptmr_q <= `PDOWN_CYC;
      end
      else if (rel_go && pdown)
      begin
         pw_q <= PW_LEAVE;
         ptmr_q <= sigd_q ? `REL_LATE_CYC : `REL_EARLY_CYC;
      end
      else if (pw_q == PW_ENTER || pw_q == PW_LEAVE)
      begin
         if (ptmr_q > `PTMR_W'(1))
            ptmr_q <= ptmr_q - `PTMR_W'(1);
         else
            pw_q <= pw_q == PW_ENTER ? PW_DOWN : PW_STBY;
      end
   end

   assign SERIAL_OUT = out_q;
   assign SERIAL_OUT_OE = oe_q;
   assign BUSY_FLAG = busy;
   assign WRITE_LATCH_FLAG = wel_q;
   assign POWERED_DOWN = pdown;
   assign MEM_ADDR = busy ? wa_q : addr_q;
   assign MEM_WE = we_q;
   assign MEM_WDATA = wdata_q;
   assign MEM_SECTOR_ERASE = serase_q;
   assign MEM_BULK_ERASE = berase_q;

   a_read_reject: assert property (@(posedge SYS_CLK) disable iff (RESET)
      (byte_done && st_q == S_CMD && busy && byte_in == `CMD_FREAD) |=> st_q == S_SKIP)
      else $error("fast read accepted while busy");
   a_pdown_reject: assert property (@(posedge SYS_CLK) disable iff (RESET)
      (byte_done && st_q == S_CMD && busy && byte_in == `CMD_PDOWN) |=> st_q == S_SKIP ##1 !exec_dp[*2])
      else $error("power-down accepted while busy");
   a_pdown_ignore: assert property (@(posedge SYS_CLK) disable iff (RESET)
      (byte_done && st_q == S_CMD && pdown && byte_in != `CMD_RELEASE) |=> st_q == S_SKIP)
      else $error("command obeyed in power-down");
   a_prog_clear: assert property (@(posedge SYS_CLK) disable iff (RESET)
      MEM_WE |-> (MEM_WDATA & ~MEM_RDATA) == 8'h00)
      else $error("program sets a bit");
   a_latch_drop: assert property (@(posedge SYS_CLK) disable iff (RESET)
      $rose(BUSY_FLAG) |-> !WRITE_LATCH_FLAG ##0 $past(WRITE_LATCH_FLAG))
      else $error("busy without write latch");
   a_bulk_prot: assert property (@(posedge SYS_CLK) disable iff (RESET)
      MEM_BULK_ERASE |-> $past(bp) == 2'h0 && op_q == OP_BERASE)
      else $error("bulk erase under protection");
   a_sector_prot: assert property (@(posedge SYS_CLK) disable iff (RESET)
      MEM_SECTOR_ERASE |-> !prot($past(bp), MEM_ADDR[17:16]))
      else $error("protected sector erased");
   a_out_stop: assert property (@(posedge SYS_CLK) disable iff (RESET)
      $rose(sel_q[1]) |=> !SERIAL_OUT_OE)
      else $error("output driven after deselect");
   a_read_wrap: assert property (@(posedge SYS_CLK) disable iff (RESET)
      (fall && st_q == S_READ && obit_q == 3'h0 && addr_q == 18'h3FFFF) |=> addr_q == 18'h00000)
      else $error("read address did not wrap");
   a_page_wrap: assert property (@(posedge SYS_CLK) disable iff (RESET)
      (byte_done && st_q == S_PDATA) |=> addr_q[17:8] == $past(addr_q[17:8]))
      else $error("program left its page");
endmodule

// File: bench/flash_host_model.sv
// Host SPI controller model driving select, serial clock and serial input
`timescale 1ns/100ps
module flash_host_model (
   input wire logic SYS_CLK,
   output logic SEL_N,
   output logic SCLK,
   output logic SERIAL_IN,
   input wire logic SERIAL_OUT
);
   initial
   begin
      SEL_N = 1'b1;
      SCLK = 1'b0;
      SERIAL_IN = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(negedge SYS_CLK);
   endtask
   // Six idle cycles keep select high past the minimum gap between frames
   task automatic begin_frame();
      wait_clk(6);
      SEL_N = 1'b0;
      wait_clk(4);
   endtask
   // Low half, then a rising edge that samples both lines; MSB first
   task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - nbits; i--)
      begin
         SCLK = 1'b0;
         SERIAL_IN = tx[i];
         wait_clk(4);
         SCLK = 1'b1;
         rx[i] = SERIAL_OUT;
         wait_clk(4);
      end
   endtask
   // Clock parks low before select rises; the released input line flips so a stale level is never seen
   task automatic end_frame();
      SCLK = 1'b0;
      wait_clk(4);
      SEL_N = 1'b1;
      SERIAL_IN = ~SERIAL_IN;
   endtask
endmodule

// File: bench/serial_flash_cmd_sequencer_tb.sv
// Self-checking bench of the serial flash command sequencer
`timescale 1ns/100ps
`include "flash_seq_map.svh"
module serial_flash_cmd_sequencer_tb;
   localparam logic [7:0] SIG = 8'h5A; // Arbitrary value
   logic sys_clk = 1'b0;
   logic reset;
   logic prot_hi;
   logic prot_lo;
   logic sel_n, sclk, serial_in, serial_out, serial_out_oe, busy, wlatch, pdown, serial_line;
   logic mem_we, serase, berase;
   logic oe_seen = 1'b0;
   logic [17:0] mem_addr;
   logic [7:0] mem_wdata, rx;
   logic [7:0] mem_rdata;
   logic [7:0] mem [0:262143];
   int n_mismatch = 0;
   int checked = 0;
   always #(`CLK_PERIOD_NS / 2.0) sys_clk = ~sys_clk;
   serial_flash_cmd_sequencer #(.PROG_TIME_US(20), .SERASE_TIME_US(5), .BERASE_TIME_US(5), .SIGNATURE(SIG)) i_dut (
      .SYS_CLK(sys_clk), .RESET(reset), .SEL_N(sel_n), .SCLK(sclk), .SERIAL_IN(serial_in),
      .SERIAL_OUT(serial_out), .SERIAL_OUT_OE(serial_out_oe), .PROTECT_LEVEL_HI(prot_hi),
      .PROTECT_LEVEL_LO(prot_lo), .BUSY_FLAG(busy), .WRITE_LATCH_FLAG(wlatch), .POWERED_DOWN(pdown),
      .MEM_ADDR(mem_addr), .MEM_RDATA(mem_rdata), .MEM_WE(mem_we), .MEM_WDATA(mem_wdata),
      .MEM_SECTOR_ERASE(serase), .MEM_BULK_ERASE(berase)
   );
   // Undriven output line shows the inverse of its last level, so a late or missing enable is caught
   assign serial_line = serial_out_oe ? serial_out : ~serial_out;
   flash_host_model i_host (
      .SYS_CLK(sys_clk), .SEL_N(sel_n), .SCLK(sclk), .SERIAL_IN(serial_in), .SERIAL_OUT(serial_line)
   );
   // Array model with one cycle of read latency
   always @(posedge sys_clk)
   begin
      mem_rdata <= mem[mem_addr];
      if (mem_we)
         mem[mem_addr] <= mem_wdata;
      if (serase)
         for (int i = 0; i < 65536; i++)
            mem[{mem_addr[17:16], 16'(i)}] <= 8'hFF;
      if (berase)
         for (int i = 0; i < 262144; i++)
            mem[i] <= 8'hFF;
      if (serial_out_oe)
         oe_seen <= 1'b1;
   end
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value %s expected %0h seen %0h", name, exp, got);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic open_cmd(input logic [7:0] op, input logic [23:0] a, input int nab);
      i_host.begin_frame();
      i_host.xfer(op, 8, rx);
      for (int i = 2; i >= 3 - nab; i--)
         i_host.xfer(a[8*i +: 8], 8, rx);
   endtask
   task automatic short_cmd(input logic [7:0] op);
      open_cmd(op, 24'h0, 0);
      i_host.end_frame();
   endtask
   task automatic wait_idle();
      int n = 0;
      while (busy !== 1'b0)
      begin
         i_host.wait_clk(1);
         n++;
         if (n > 4000)
         begin
            n_mismatch++;
            $display("wrong value busy_wait expected 0 seen 1");
            conclude();
         end
      end
   endtask
   // Write-enable, then the operation; nbits of a zero data byte follow the address
   task automatic wr_op(input logic [7:0] op, input logic [23:0] a, input int nab, input int nbits, input logic exp);
      short_cmd(`CMD_WREN);
      open_cmd(op, a, nab);
      if (nbits > 0)
         i_host.xfer(8'h00, nbits, rx);
      i_host.end_frame();
      i_host.wait_clk(6);
      chk("busy_after_op", 8'(exp), 8'(busy));
   endtask
   task automatic t_read();
      mem[18'h3FFFF] = 8'hA5;
      mem[18'h00000] = 8'h3C;
      open_cmd(`CMD_FREAD, 24'h03FFFF, 3);
      i_host.xfer(8'h00, 8, rx);
      i_host.xfer(8'h00, 8, rx);
      chk("read_top", 8'hA5, rx);
      i_host.xfer(8'h00, 8, rx);
      chk("read_wrap", 8'h3C, rx);
      i_host.xfer(8'h00, 3, rx);
      i_host.end_frame();
      i_host.wait_clk(5);
      chk("oe_after_stop", 8'h00, 8'(serial_out_oe));
      $display("test read done");
   endtask
   task automatic t_prog();
      mem[18'h100FE] = 8'h0F;
      mem[18'h10001] = 8'h77;
      open_cmd(`CMD_PROG, 24'h0100FE, 3);
      i_host.xfer(8'h00, 8, rx);
      i_host.end_frame();
      i_host.wait_clk(6);
      chk("no_latch_prog", 8'h00, 8'(busy));
      short_cmd(`CMD_WREN);
      i_host.wait_clk(6);
      chk("latch_set", 8'h01, 8'(wlatch));
      open_cmd(`CMD_PROG, 24'h0100FE, 3);
      i_host.xfer(8'hF1, 8, rx);
      i_host.xfer(8'h22, 8, rx);
      i_host.xfer(8'h33, 8, rx);
      i_host.end_frame();
      i_host.wait_clk(6);
      chk("busy_prog", 8'h01, 8'(busy));
      chk("latch_cleared", 8'h00, 8'(wlatch));
      oe_seen = 1'b0;
      open_cmd(`CMD_FREAD, 24'h0, 3);
      i_host.xfer(8'h00, 8, rx);
      i_host.xfer(8'h00, 8, rx);
      i_host.end_frame();
      chk("read_while_busy", 8'h00, 8'(oe_seen));
      short_cmd(`CMD_PDOWN);
      i_host.wait_clk(6);
      chk("pdown_while_busy", 8'h00, 8'(pdown));
      chk("busy_kept", 8'h01, 8'(busy));
      wait_idle();
      chk("and_old_new", 8'h01, mem[18'h100FE]);
      chk("byte_last", 8'h22, mem[18'h100FF]);
      chk("page_wrap", 8'h33, mem[18'h10000]);
      chk("untouched", 8'h77, mem[18'h10001]);
      wr_op(`CMD_PROG, 24'h010010, 3, 7, 1'b0);
      $display("test program done");
   endtask
   task automatic t_protect();
      mem[18'h20000] = 8'h12;
      prot_lo = 1'b1;
      wr_op(`CMD_PROG, 24'h030000, 3, 8, 1'b0);
      wr_op(`CMD_SERASE, 24'h030000, 3, 0, 1'b0);
      wr_op(`CMD_BERASE, 24'h0, 0, 0, 1'b0);
      prot_lo = 1'b0;
      prot_hi = 1'b1;
      wr_op(`CMD_PROG, 24'h020000, 3, 8, 1'b0);
      wr_op(`CMD_SERASE, 24'h000000, 3, 0, 1'b1);
      wait_idle();
      chk("low_sector_erased", 8'hFF, mem[18'h00000]);
      prot_hi = 1'b0;
      wr_op(`CMD_SERASE, 24'h01ABCD, 3, 0, 1'b1);
      wait_idle();
      chk("sector_erased", 8'hFF, mem[18'h100FE]);
      chk("other_sector", 8'h12, mem[18'h20000]);
      wr_op(`CMD_BERASE, 24'h0, 0, 0, 1'b1);
      wait_idle();
      chk("bulk_erased", 8'hFF, mem[18'h20000]);
      $display("test protect done");
   endtask
   task automatic t_power(input int nsig, input int lo, input int hi);
      int n = 0;
      short_cmd(`CMD_PDOWN);
      i_host.wait_clk(6);
      chk("pd_entered", 8'h01, 8'(pdown));
      short_cmd(`CMD_WREN);
      i_host.wait_clk(6);
      chk("cmd_in_pd", 8'h00, 8'(wlatch));
      open_cmd(`CMD_RELEASE, 24'h0, (nsig > 0) ? 3 : 0);
      for (int i = 0; i < nsig; i++)
      begin
         i_host.xfer(8'h00, 8, rx);
         chk("signature", SIG, rx);
      end
      i_host.end_frame();
      while (pdown === 1'b1 && n < 400)
      begin
         i_host.wait_clk(1);
         n++;
      end
      chk("release_delay", 8'h01, 8'(n >= lo && n <= hi));
      if (n >= 400)
         conclude();
      $display("test power %0d done", nsig);
   endtask
   initial
   begin
      reset = 1'b1;
      prot_hi = 1'b0;
      prot_lo = 1'b0;
      for (int i = 0; i < 262144; i++)
         mem[i] = 8'hFF;
      repeat (20) @(negedge sys_clk);
      reset = 1'b0;
      t_read();
      t_prog();
      t_protect();
      t_power(2, 79, 88);
      t_power(0, 119, 128);
      conclude();
   end
endmodule
